//--- design/synth_serial_prog_regs.sv
// write-only serial register bank and modulation data path of a dual synthesizer
// assumes clk_sys is the reference oscillator; link pins are asynchronous to it
`default_nettype none

module synth_serial_prog_regs (
    input  wire logic                                        clk_sys,
    input  wire logic                                        srst,
    input  wire logic                                        link_sclk,
    input  wire logic                                        cs_n,
    input  wire logic                                        sdata,
    input  wire logic                                        mod_in,
    input  wire logic                                        divided_main_vco_clock,
    output logic [synth_prog_pkg::DIV_INDEX_W-1:0]           main_index_applied,
    output logic signed [synth_prog_pkg::MAIN_DIVIDEND_W-1:0] main_dividend_applied,
    output logic                                             main_int_mode,
    output logic                                             main_10bit_mode,
    output logic [synth_prog_pkg::DIV_INDEX_W-1:0]           aux_index_applied,
    output logic signed [synth_prog_pkg::AUX_DIVIDEND_W-1:0] aux_dividend_applied,
    output logic [synth_prog_pkg::DATA_W-1:0]                ref_divider_indices,
    output logic [synth_prog_pkg::DATA_W-1:0]                detector_gain_control,
    output logic [synth_prog_pkg::DATA_W-1:0]                powerdown_output_select,
    output logic signed [synth_prog_pkg::MOD_OUT_W-1:0]      modulation_applied,
    output logic                                             modulation_update,
    output logic                                             frame_discarded
);

    localparam int DW  = synth_prog_pkg::DATA_W;
    localparam int CW  = synth_prog_pkg::CNT_W;
    localparam int FL  = synth_prog_pkg::FULL_LEN;

    // sign-extend the low len bits of a short sample to full width
    function automatic logic [DW-1:0] sext_sample(input logic [DW-1:0] raw, input logic [CW-1:0] len);
        logic [DW-1:0] res;

        res = '0;
        for (int i = 0; i < DW; i++)
        begin
            if (i < int'(len))
                res[i] = raw[i];
            else
                res[i] = raw[int'(len) - 1];
        end
        return res;
    endfunction : sext_sample

    // link-side capture
    logic [FL-1:0] frame_data;
    logic [DW-1:0] frame_alt;
    logic [CW-1:0] frame_len;
    logic          frame_toggle;

    serial_frame_capture u_capture (
        .link_sclk    (link_sclk),
        .srst         (srst),
        .cs_n         (cs_n),
        .sdata        (sdata),
        .mod_in       (mod_in),
        .frame_data   (frame_data),
        .frame_alt    (frame_alt),
        .frame_len    (frame_len),
        .frame_toggle (frame_toggle)
    );

    // crossing into the reference domain
    logic [1:0] pins_sync;
    logic       toggle_sync;
    logic       vco_sync;

    sync_2ff #(
        .W (2)
    ) u_sync_pins (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .async_in ({frame_toggle, divided_main_vco_clock}),
        .sync_out (pins_sync)
    );

    assign toggle_sync = pins_sync[1];
    assign vco_sync    = pins_sync[0];

    // reference-side edges
    logic toggle_seen_r;
    logic vco_prev_r;

    logic frame_event;
    logic vco_fall;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            toggle_seen_r <= 1'b0;
            vco_prev_r    <= 1'b0;
        end
        else
        begin
            toggle_seen_r <= toggle_sync;
            vco_prev_r    <= vco_sync;
        end
    end

    // one pulse per landed frame
    assign frame_event = toggle_sync ^ toggle_seen_r;

    assign vco_fall    = vco_prev_r & ~vco_sync;

    // frame classification; captured words are stable while the event is seen
    logic                                   is_full;
    logic                                   is_short;

    logic [synth_prog_pkg::ADDR_W-1:0]      full_addr;
    logic [DW-1:0]                          full_data;
    logic [DW-1:0]                          short_raw;
    logic [DW-1:0]                          short_sample;

    logic                                   reg_wr;

    assign is_full   = frame_event && (frame_len == CW'(synth_prog_pkg::FULL_LEN));
    assign is_short  = frame_event && (frame_len >= CW'(synth_prog_pkg::SHORT_MIN))
                       && (frame_len <= CW'(synth_prog_pkg::SHORT_MAX));

    assign full_addr = frame_data[FL-1:DW];
    assign full_data = frame_data[DW-1:0];
    assign reg_wr    = is_full && (full_addr < 4'(synth_prog_pkg::NUM_REGS));

    // register file, write only
    logic [DW-1:0] main_integer_divider_r;
    logic [DW-1:0] main_fraction_upper_r;
    logic [DW-1:0] main_fraction_lower_r;
    logic [DW-1:0] aux_integer_divider_r;
    logic [DW-1:0] aux_fraction_r;

    // configuration words
    logic [DW-1:0] ref_divider_indices_r;
    logic [DW-1:0] detector_gain_control_r;
    logic [DW-1:0] powerdown_output_select_r;

    // modulation words
    logic [DW-1:0] modulation_setup_r;
    logic [DW-1:0] modulation_sample_r;

    // alternate pin selection for short strobes
    assign short_raw    = modulation_setup_r[synth_prog_pkg::MODSET_ALT_BIT] ? frame_alt
                                                                             : frame_data[DW-1:0];
    assign short_sample = sext_sample(short_raw, frame_len);

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            main_integer_divider_r    <= synth_prog_pkg::RST_DIVIDER;
            main_fraction_upper_r     <= synth_prog_pkg::RST_OTHER;
            main_fraction_lower_r     <= synth_prog_pkg::RST_OTHER;
            aux_integer_divider_r     <= synth_prog_pkg::RST_DIVIDER;
            aux_fraction_r            <= synth_prog_pkg::RST_OTHER;
            ref_divider_indices_r     <= synth_prog_pkg::RST_OTHER;
            detector_gain_control_r   <= synth_prog_pkg::RST_OTHER;
            powerdown_output_select_r <= synth_prog_pkg::RST_OTHER;
            modulation_setup_r        <= synth_prog_pkg::RST_OTHER;
        end
        else if (reg_wr)
        begin
            unique case (full_addr)
                synth_prog_pkg::ADDR_MAIN_INTEGER_DIVIDER:    main_integer_divider_r    <= full_data;
                synth_prog_pkg::ADDR_MAIN_FRACTION_UPPER:     main_fraction_upper_r     <= full_data;
                synth_prog_pkg::ADDR_MAIN_FRACTION_LOWER:     main_fraction_lower_r     <= full_data;
                synth_prog_pkg::ADDR_AUX_INTEGER_DIVIDER:     aux_integer_divider_r     <= full_data;
                synth_prog_pkg::ADDR_AUX_FRACTION:            aux_fraction_r            <= full_data;
                synth_prog_pkg::ADDR_REF_DIVIDER_INDICES:     ref_divider_indices_r     <= full_data;
                synth_prog_pkg::ADDR_DETECTOR_GAIN_CONTROL:   detector_gain_control_r   <= full_data;
                synth_prog_pkg::ADDR_POWERDOWN_OUTPUT_SELECT: powerdown_output_select_r <= full_data;
                synth_prog_pkg::ADDR_MODULATION_SETUP:        modulation_setup_r        <= full_data;
                default:                                      ;
            endcase
        end
    end

    // modulation sample register: full write to address 9 or short strobe
    logic mod_written;

    assign mod_written = (reg_wr && (full_addr == synth_prog_pkg::ADDR_MODULATION_SAMPLE))
                         || is_short;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            modulation_sample_r <= synth_prog_pkg::RST_OTHER;
        else if (is_short)
            modulation_sample_r <= short_sample;
        else if (mod_written)
            modulation_sample_r <= full_data;
    end

    // transfer to the modulation unit on the falling divided vco edge
    logic                                 mod_pending_r;

    logic [synth_prog_pkg::MODSET_SHIFT_W-1:0] mod_shift;
    logic signed [synth_prog_pkg::MOD_OUT_W-1:0] mod_scaled;

    assign mod_shift  = modulation_setup_r[synth_prog_pkg::MODSET_SHIFT_LSB +: synth_prog_pkg::MODSET_SHIFT_W];

    // scale by two to the m
    assign mod_scaled = synth_prog_pkg::MOD_OUT_W'($signed(modulation_sample_r)) <<< mod_shift;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            mod_pending_r <= 1'b0;
        else if (mod_written)
            mod_pending_r <= 1'b1;
        else if (vco_fall)
            mod_pending_r <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            modulation_applied <= '0;
            modulation_update  <= 1'b0;
        end
        else
        begin
            modulation_update <= vco_fall && mod_pending_r;
            if (vco_fall && mod_pending_r)
                modulation_applied <= mod_scaled;
        end
    end

    // mode bits
    logic main_int_now;
    logic main_10bit_now;
    logic aux_int_now;

    assign main_int_now   = powerdown_output_select_r[synth_prog_pkg::PWR_MAIN_INT_BIT];
    assign main_10bit_now = powerdown_output_select_r[synth_prog_pkg::PWR_MAIN_10BIT_BIT];
    assign aux_int_now    = powerdown_output_select_r[synth_prog_pkg::PWR_AUX_INT_BIT];

    // applied divide ratios of the main synthesizer
    logic signed [synth_prog_pkg::MAIN_DIVIDEND_W-1:0] new_main_dividend;
    logic [synth_prog_pkg::FRAC_UPPER_W-1:0]           upper_bits;

    assign upper_bits        = full_data[synth_prog_pkg::FRAC_UPPER_W-1:0];

    // 10-bit mode skips the lower word
    assign new_main_dividend = main_10bit_now
        ? synth_prog_pkg::MAIN_DIVIDEND_W'($signed(upper_bits))
        : $signed({upper_bits, main_fraction_lower_r[synth_prog_pkg::FRAC_LOWER_W-1:0]});

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            main_index_applied    <= synth_prog_pkg::RST_DIVIDER[synth_prog_pkg::DIV_INDEX_W-1:0];
            main_dividend_applied <= '0;
        end
        else if (reg_wr && full_addr == synth_prog_pkg::ADDR_MAIN_FRACTION_UPPER)
        begin
            main_index_applied    <= main_integer_divider_r[synth_prog_pkg::DIV_INDEX_W-1:0];
            main_dividend_applied <= new_main_dividend;
        end
        else if (reg_wr && full_addr == synth_prog_pkg::ADDR_MAIN_INTEGER_DIVIDER && main_int_now)
        begin
            main_index_applied <= full_data[synth_prog_pkg::DIV_INDEX_W-1:0];
        end
    end

    // applied divide ratios of the auxiliary synthesizer
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            aux_index_applied    <= synth_prog_pkg::RST_DIVIDER[synth_prog_pkg::DIV_INDEX_W-1:0];
            aux_dividend_applied <= '0;
        end
        else if (reg_wr && full_addr == synth_prog_pkg::ADDR_AUX_FRACTION)
        begin
            aux_index_applied    <= aux_integer_divider_r[synth_prog_pkg::DIV_INDEX_W-1:0];
            aux_dividend_applied <= $signed(full_data[synth_prog_pkg::AUX_DIVIDEND_W-1:0]);
        end
        else if (reg_wr && full_addr == synth_prog_pkg::ADDR_AUX_INTEGER_DIVIDER && aux_int_now)
        begin
            aux_index_applied <= full_data[synth_prog_pkg::DIV_INDEX_W-1:0];
        end
    end

    // discarded frames: wrong length or unmapped address
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            frame_discarded <= 1'b0;
        else
            frame_discarded <= frame_event && !is_short && !reg_wr
                               && !(is_full && full_addr == synth_prog_pkg::ADDR_MODULATION_SAMPLE);
    end

    // registered configuration outputs; nothing is ever read back over the link
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            main_int_mode           <= 1'b0;
            main_10bit_mode         <= 1'b0;
            ref_divider_indices     <= synth_prog_pkg::RST_OTHER;
            detector_gain_control   <= synth_prog_pkg::RST_OTHER;
            powerdown_output_select <= synth_prog_pkg::RST_OTHER;
        end
        else
        begin
            main_int_mode           <= main_int_now;
            main_10bit_mode         <= main_10bit_now;
            ref_divider_indices     <= ref_divider_indices_r;
            detector_gain_control   <= detector_gain_control_r;
            powerdown_output_select <= powerdown_output_select_r;
        end
    end

endmodule : synth_serial_prog_regs

`default_nettype wire

//--- design/synth_prog_pkg.sv
// constants for the serial programming register bank of the dual synthesizer
// assumes nothing beyond a sv-2012 compiler
`default_nettype none

package synth_prog_pkg;

    // serial word layout
    localparam int DATA_W       = 12;
    localparam int ADDR_W       = 4;
    localparam int FULL_LEN     = 16;
    localparam int SHORT_MIN    = 2;
    localparam int SHORT_MAX    = 12;
    localparam int CNT_W        = 5;
    localparam int NUM_REGS     = 10;

    // register addresses
    localparam logic [3:0] ADDR_MAIN_INTEGER_DIVIDER    = 4'h0;
    localparam logic [3:0] ADDR_MAIN_FRACTION_UPPER     = 4'h1;
    localparam logic [3:0] ADDR_MAIN_FRACTION_LOWER     = 4'h2;
    localparam logic [3:0] ADDR_AUX_INTEGER_DIVIDER     = 4'h3;
    localparam logic [3:0] ADDR_AUX_FRACTION            = 4'h4;
    localparam logic [3:0] ADDR_REF_DIVIDER_INDICES     = 4'h5;
    localparam logic [3:0] ADDR_DETECTOR_GAIN_CONTROL   = 4'h6;
    localparam logic [3:0] ADDR_POWERDOWN_OUTPUT_SELECT = 4'h7;
    localparam logic [3:0] ADDR_MODULATION_SETUP        = 4'h8;
    localparam logic [3:0] ADDR_MODULATION_SAMPLE       = 4'h9;

    // reset values
    localparam logic [11:0] RST_DIVIDER = 12'h006;
    localparam logic [11:0] RST_OTHER   = 12'h000;

    // field widths
    localparam int DIV_INDEX_W     = 9;
    localparam int FRAC_UPPER_W    = 10;
    localparam int FRAC_LOWER_W    = 8;
    localparam int MAIN_DIVIDEND_W = 18;
    localparam int AUX_DIVIDEND_W  = 10;

    // modulation setup fields
    localparam int MODSET_SHIFT_LSB = 0;
    localparam int MODSET_SHIFT_W   = 4;
    localparam int MODSET_ALT_BIT   = 4;
    localparam int MOD_OUT_W        = 27;

    // powerdown / output select mode bits
    localparam int PWR_MAIN_INT_BIT   = 2;
    localparam int PWR_MAIN_10BIT_BIT = 9;
    localparam int PWR_AUX_INT_BIT    = 10;

endpackage : synth_prog_pkg

`default_nettype wire

//--- design/sync_2ff.sv
// two flip-flop synchroniser for levels arriving from another clock domain
// assumes srst is synchronous to clk_sys
`default_nettype none

module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
        end
    end

    assign sync_out = stage2_r;

endmodule : sync_2ff

`default_nettype wire

//--- design/serial_frame_capture.sv
// link-side capture of one chip-select frame on the serial clock
// assumes the serial clock runs only while chip select is low; srst clears the held frame and the toggle
`default_nettype none

module serial_frame_capture (
    input  wire logic                              link_sclk,
    input  wire logic                              srst,
    input  wire logic                              cs_n,
    input  wire logic                              sdata,
    input  wire logic                              mod_in,
    output logic [synth_prog_pkg::FULL_LEN-1:0]    frame_data,
    output logic [synth_prog_pkg::DATA_W-1:0]      frame_alt,
    output logic [synth_prog_pkg::CNT_W-1:0]       frame_len,
    output logic                                   frame_toggle
);

    logic [synth_prog_pkg::CNT_W-1:0]    cnt_r;
    logic [synth_prog_pkg::FULL_LEN-1:0] sh_data_r;
    logic [synth_prog_pkg::DATA_W-1:0]   sh_alt_r;

    // bit counter, saturating, cleared by the frame end itself
    always_ff @(posedge link_sclk or posedge cs_n)
    begin
        if (cs_n)
            cnt_r <= '0;
        else if (cnt_r != '1)
            cnt_r <= cnt_r + 1'b1;
    end

    // msb first shifting of both data pins
    always_ff @(posedge link_sclk)
    begin
        if (!cs_n)
        begin
            sh_data_r <= {sh_data_r[synth_prog_pkg::FULL_LEN-2:0], sdata};
            sh_alt_r  <= {sh_alt_r[synth_prog_pkg::DATA_W-2:0], mod_in};
        end
    end

    // hold the frame at chip-select release and flag it by toggle
    always_ff @(posedge cs_n or posedge srst)
    begin
        if (srst)
        begin
            frame_data   <= '0;
            frame_alt    <= '0;
            frame_len    <= '0;
            frame_toggle <= 1'b0;
        end
        else
        begin
            frame_data   <= sh_data_r;
            frame_alt    <= sh_alt_r;
            frame_len    <= cnt_r;
            frame_toggle <= ~frame_toggle;
        end
    end

endmodule : serial_frame_capture

`default_nettype wire

//--- test/synth_prog_properties.sv
// checker for the serial register bank, watching the top ports only
// assumes one clk_sys domain with srst synchronous active high
`default_nettype none

module synth_prog_properties (
    input wire logic               clk_sys,
    input wire logic               srst,
    input wire logic               cs_n,
    input wire logic               divided_main_vco_clock,
    input wire logic [8:0]         main_index_applied,
    input wire logic signed [17:0] main_dividend_applied,
    input wire logic               main_10bit_mode,
    input wire logic [8:0]         aux_index_applied,
    input wire logic signed [9:0]  aux_dividend_applied,
    input wire logic [11:0]        ref_divider_indices,
    input wire logic [11:0]        detector_gain_control,
    input wire logic [11:0]        powerdown_output_select,
    input wire logic signed [26:0] modulation_applied,
    input wire logic               modulation_update,
    input wire logic               frame_discarded
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence link_idle;
        cs_n [*8];
    endsequence
    sequence vco_steady;
        $stable(divided_main_vco_clock) [*8];
    endsequence
    sequence cfg_still;
        $stable(ref_divider_indices) && $stable(detector_gain_control) && $stable(powerdown_output_select);
    endsequence

    cfg_hold_a:
        assert property (link_idle |=> cfg_still) else $error("config changed with link idle");
    ratio_hold_a:
        assert property (link_idle |=> $stable(main_index_applied) && $stable(main_dividend_applied)
            && $stable(aux_index_applied) && $stable(aux_dividend_applied)) else $error("ratio changed with link idle");
    discard_keep_a:
        assert property (frame_discarded |=> cfg_still [*3]) else $error("discarded frame changed a register");
    discard_pulse_a:
        assert property (frame_discarded |=> !frame_discarded) else $error("discard flag held too long");
    mod_cause_a:
        assert property (!$stable(modulation_applied) |-> modulation_update) else $error("modulation moved without update");
    update_pulse_a:
        assert property (modulation_update |=> !modulation_update) else $error("update pulse held too long");
    vco_quiet_a:
        assert property (vco_steady |=> !modulation_update) else $error("update without a vco fall");
    reset_value_a:
        assert property (disable iff (1'b0) srst |=> main_index_applied == 9'h006 && aux_index_applied == 9'h006
            && modulation_applied == 27'h0 && powerdown_output_select == 12'h000) else $error("bad reset value");
    ten_bit_sign_a:
        assert property (main_10bit_mode && !$stable(main_dividend_applied) |-> main_dividend_applied[17:9] == 9'h000
            || main_dividend_applied[17:9] == 9'h1ff) else $error("10-bit dividend not sign extended");
endmodule : synth_prog_properties

bind synth_serial_prog_regs synth_prog_properties chk_u (.clk_sys(clk_sys), .srst(srst), .cs_n(cs_n),
    .divided_main_vco_clock(divided_main_vco_clock), .main_index_applied(main_index_applied),
    .main_dividend_applied(main_dividend_applied), .main_10bit_mode(main_10bit_mode),
    .aux_index_applied(aux_index_applied), .aux_dividend_applied(aux_dividend_applied),
    .ref_divider_indices(ref_divider_indices), .detector_gain_control(detector_gain_control),
    .powerdown_output_select(powerdown_output_select), .modulation_applied(modulation_applied),
    .modulation_update(modulation_update), .frame_discarded(frame_discarded));

`default_nettype wire

//--- test/host_link_model.sv
// host side of the four-wire link: chip select, serial clock, data and alternate data
// assumes frames are started by the bench through send; the link clock stands still between frames
`default_nettype none

module host_link_model (
    output logic link_sclk,
    output logic cs_n,
    output logic sdata,
    output logic mod_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        link_sclk = 1'b0;
        cs_n      = 1'b1;
        sdata     = 1'b0;
        mod_in    = 1'b0;
    end

    // n bits msb first on a 15 ns link clock; released lines show the inverse level
    task automatic send(input int n, input logic [16:0] d, input logic [11:0] alt);
        #3.3;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdata  = d[i];
            mod_in = (i < 12) ? alt[i] : ~alt[0];
            #7.5 link_sclk = 1'b1;
            #7.5 link_sclk = 1'b0;
        end
        #4 cs_n = 1'b1;
        sdata  = ~sdata;
        mod_in = ~mod_in;
        #60;
    endtask : send
endmodule : host_link_model

`default_nettype wire

//--- test/test_synth_serial_prog_regs.sv
// self-checking bench for the serial register bank
// assumes host_link_model drives the link and the checker is bound to the design
`default_nettype none

module test_synth_serial_prog_regs;
    timeunit 1ns;
    timeprecision 100ps;

    logic               clk_sys, srst, vco, link_sclk, cs_n, sdata, mod_in;
    logic               main_int_mode, main_10bit_mode, modulation_update, frame_discarded;
    logic [8:0]         main_index_applied, aux_index_applied;
    logic signed [17:0] main_dividend_applied;
    logic signed [9:0]  aux_dividend_applied;
    logic [11:0]        ref_divider_indices, detector_gain_control, powerdown_output_select;
    logic signed [26:0] modulation_applied;
    int                 bad_count = 0;
    int                 n_checks = 0;
    int                 disc_n = 0;

    host_link_model host_u (.link_sclk(link_sclk), .cs_n(cs_n), .sdata(sdata), .mod_in(mod_in));

    synth_serial_prog_regs dut_u (.clk_sys(clk_sys), .srst(srst), .link_sclk(link_sclk), .cs_n(cs_n),
        .sdata(sdata), .mod_in(mod_in), .divided_main_vco_clock(vco), .main_index_applied(main_index_applied),
        .main_dividend_applied(main_dividend_applied), .main_int_mode(main_int_mode),
        .main_10bit_mode(main_10bit_mode), .aux_index_applied(aux_index_applied),
        .aux_dividend_applied(aux_dividend_applied), .ref_divider_indices(ref_divider_indices),
        .detector_gain_control(detector_gain_control), .powerdown_output_select(powerdown_output_select),
        .modulation_applied(modulation_applied), .modulation_update(modulation_update),
        .frame_discarded(frame_discarded));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
        if (frame_discarded === 1'b1)
            disc_n++;

    task automatic chk(input string what, input logic [26:0] seen, input logic [26:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        host_u.send(16, {1'b0, a, d}, 12'hfff);
        repeat (8) @(posedge clk_sys);
    endtask : wr

    task automatic vfall();
        vco <= 1'b0;
        repeat (8) @(posedge clk_sys);
        vco <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : vfall

    task automatic t_reset();
        chk("main_index", main_index_applied, 27'h6);
        chk("aux_index", aux_index_applied, 27'h6);
        chk("dividend", {main_dividend_applied}, 27'h0);
        chk("cfg", ref_divider_indices | detector_gain_control | powerdown_output_select, 27'h0);
        chk("mod", modulation_applied, 27'h0);
        chk("aux_frac", {aux_dividend_applied}, 27'h0);
        $display("done reset");
    endtask : t_reset

    task automatic t_config();
        wr(4'h5, 12'h5a3);
        wr(4'h6, 12'hc3c);
        wr(4'h7, 12'h1f3);
        chk("ref_div", ref_divider_indices, 27'h5a3);
        chk("gain", detector_gain_control, 27'hc3c);
        chk("pwr", powerdown_output_select, 27'h1f3);
        chk("int_mode", main_int_mode, 27'h0);
        $display("done config");
    endtask : t_config

    task automatic t_frac18();
        wr(4'h0, 12'h00d);
        wr(4'h2, 12'h098);
        chk("idx_early", main_index_applied, 27'h6);
        wr(4'h1, 12'h07d);
        chk("idx", main_index_applied, 27'h00d);
        chk("dividend", {main_dividend_applied}, 27'h07d98);
        wr(4'h1, 12'h3ff);
        chk("neg_sign", main_dividend_applied < 0, 27'h1);
        $display("done fraction");
    endtask : t_frac18

    task automatic t_tenbit();
        wr(4'h7, 12'h200);
        wr(4'h2, 12'h055);
        wr(4'h1, 12'h334);
        chk("mode10", main_10bit_mode, 27'h1);
        chk("div10", {main_dividend_applied}, 27'h3ff34);
        $display("done ten bit");
    endtask : t_tenbit

    task automatic t_integer();
        wr(4'h7, 12'h404);
        chk("int_mode", main_int_mode, 27'h1);
        wr(4'h0, 12'h1ff);
        chk("int_idx", main_index_applied, 27'h1ff);
        wr(4'h3, 12'h012);
        chk("aux_idx", aux_index_applied, 27'h012);
        wr(4'h4, 12'h2c1);
        chk("aux_frac", {aux_dividend_applied}, 27'h2c1);
        wr(4'h7, 12'h000);
        $display("done integer");
    endtask : t_integer

    task automatic t_short();
        logic [26:0] prev;
        prev = 27'h0;
        wr(4'h8, 12'h000);
        for (int n = 2; n <= 12; n++)
        begin
            host_u.send(n, 17'((1 << (n - 1)) - 1), 12'hfff);
            repeat (8) @(posedge clk_sys);
            chk("held", modulation_applied, prev);
            vfall();
            prev = 27'((1 << (n - 1)) - 1);
            chk("short", modulation_applied, prev);
        end
        $display("done short");
    endtask : t_short

    task automatic t_alt();
        wr(4'h8, 12'h013);
        host_u.send(4, 17'h0, 12'h009);
        repeat (8) @(posedge clk_sys);
        vfall();
        chk("alt_shift", modulation_applied, 27'h7ffffc8);
        wr(4'h9, 12'h005);
        vfall();
        chk("full_mod", modulation_applied, 27'h28);
        $display("done alternate");
    endtask : t_alt

    task automatic t_discard();
        int d0;
        d0 = disc_n;
        host_u.send(13, 17'h1ffff, 12'hfff);
        host_u.send(15, 17'h1ffff, 12'hfff);
        host_u.send(17, 17'h1ffff, 12'hfff);
        wr(4'ha, 12'hfff);
        vfall();
        chk("discards", 27'(disc_n - d0), 27'h4);
        chk("kept_ref", ref_divider_indices, 27'h5a3);
        chk("kept_mod", modulation_applied, 27'h28);
        $display("done discard");
    endtask : t_discard

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // tests take about 12.8 us; 200 us cuts a hang
    initial
    begin
        #200us;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        srst = 1'b1;
        vco  = 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_reset();
        t_config();
        t_frac18();
        t_tenbit();
        t_integer();
        t_short();
        t_alt();
        t_discard();
        srst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_reset();
        tally_and_finish();
    end
endmodule : test_synth_serial_prog_regs

`default_nettype wire
